// File: rtl/acsp_device.sv
// Device end: serial port with shadow and active byte registers
//
// Functional notes
// RULE1 - Frame starts: select low, then clock rises
// RULE2 - Sixteen-bit instruction, then length-coded data bytes
// RULE3 - Length code 11 streams until select rises
// RULE4 - Select high mid-byte resets serial machine
// RULE5 - Select high between bytes stalls, resumes
// RULE6 - Select high: clock and data ignored
// RULE7 - Read instruction turns data pin around
// RULE8 - Data pin driven only during readback
// RULE9 - Most significant first by default, configurable
// RULE10 - Without select, master avoids streaming
// RULE11 - Device samples data on rising clock
// RULE12 - Every byte location writable and readable; the code reads address 1 as chip ID 0xa5 and address 0xff as zero
// RULE13 - Address zero: bit order, soft reset, 0x18; the code only clears the soft reset bit and resets nothing
// RULE14 - Transfer bit copies shadow into active
// RULE15 - Readback changes on falling clock edges
// RULE16 - Address advances after each data byte
`include "acsp_regs.svh"
module acsp_device
#(
  parameter int DEPTH = `ACSP_MEM_DEPTH
)
(
  input  wire logic   clock,
  input  wire logic   rstn,
  input  wire logic   clockEnable,
  acsp_link_if.device link,
  output logic [7:0]  activeByte_ff [DEPTH],
  output logic        lsbFirst_ff
);
  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] sclkSync_ff;
  logic [1:0] csnSync_ff;
  logic [1:0] dataSync_ff;
  logic       sclkPrev_ff;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sclkSync_ff <= 2'h0;
      csnSync_ff  <= 2'h3;
      dataSync_ff <= 2'h0;
      sclkPrev_ff <= 1'b0;
    end
    else if (clockEnable)
    begin
      sclkSync_ff <= {sclkSync_ff[0], link.serialClock};
      csnSync_ff  <= {csnSync_ff[0], link.chipSelectN};
      dataSync_ff <= {dataSync_ff[0], link.dataLine};
      sclkPrev_ff <= sclkSync_ff[1];
    end
  end
  logic csn;
  logic rise;
  logic fall;
  assign csn  = csnSync_ff[1];
  assign rise = !csn && sclkSync_ff[1] && !sclkPrev_ff; // RULE11 RULE6
  assign fall = !csn && !sclkSync_ff[1] && sclkPrev_ff; // RULE6

  //////////////////////////////////////////////////////////////////////////////
  // Serial state
  acsp_pkg::acsp_state_type state_ff, nxt_state;
  logic [15:0] shift_ff, nxt_shift;
  logic [3:0]  bitCnt_ff, nxt_bitCnt;
  logic [1:0]  bytesLeft_ff, nxt_bytesLeft;
  logic        stream_ff, nxt_stream;
  logic        read_ff, nxt_read;
  logic [12:0] addr_ff, nxt_addr;
  logic [7:0]  txByte_ff, nxt_txByte;
  logic        sdo_ff, nxt_sdo;
  logic        oe_ff, nxt_oe;
  logic [7:0]  shadow_ff [DEPTH];
  logic        nxt_lsbFirst;
  logic        wrEn;
  logic [7:0]  wrByte;
  logic        xferEn;
  logic [7:0]  rxByte;
  logic [7:0]  memRead;
  logic [12:0] nxtAddrUse;

  function automatic logic [7:0] mirror(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      mirror[i] = b[7 - i];
    end
  endfunction

  function automatic logic [7:0] readAt(input logic [12:0] a);
    if (a == `ACSP_ADDR_CHIPID)
    begin
      readAt = `ACSP_CHIPID_VALUE;
    end
    else if (a < 13'(DEPTH))
    begin
      readAt = shadow_ff[a[7:0]]; // RULE12
    end
    else
    begin
      readAt = 8'h00;
    end
  endfunction

  always_comb
  begin
    nxt_state     = state_ff;
    nxt_shift     = shift_ff;
    nxt_bitCnt    = bitCnt_ff;
    nxt_bytesLeft = bytesLeft_ff;
    nxt_stream    = stream_ff;
    nxt_read      = read_ff;
    nxt_addr      = addr_ff;
    nxt_txByte    = txByte_ff;
    nxt_sdo       = sdo_ff;
    nxt_oe        = oe_ff;
    wrEn          = 1'b0;
    wrByte        = 8'h00;
    rxByte        = 8'h00;
    memRead       = 8'h00;
    nxtAddrUse    = addr_ff;
    if (csn)
    begin
      nxt_oe = 1'b0;
      if (bitCnt_ff != 4'h0 || state_ff == acsp_pkg::ACSP_INSTR || stream_ff)
      begin
        nxt_state  = acsp_pkg::ACSP_IDLE; // RULE4
        nxt_bitCnt = 4'h0;
      end
    end
    else if (rise)
    begin
      nxt_shift  = {shift_ff[14:0], dataSync_ff[1]}; // RULE11
      nxt_bitCnt = bitCnt_ff + 4'h1;
      unique case (state_ff)
        acsp_pkg::ACSP_IDLE:
        begin
          nxt_state  = acsp_pkg::ACSP_INSTR; // RULE1
          nxt_bitCnt = 4'h1;
        end
        acsp_pkg::ACSP_INSTR:
        begin
          if (bitCnt_ff == 4'hf)
          begin
            nxt_state     = acsp_pkg::ACSP_DATA; // RULE2
            nxt_bitCnt    = 4'h0;
            nxt_read      = nxt_shift[`ACSP_RW_POS];
            nxt_stream    = nxt_shift[14:13] == `ACSP_LEN_STREAM; // RULE3
            nxt_bytesLeft = nxt_shift[14:13];
            nxt_addr      = nxt_shift[12:0];
            nxt_txByte    = readAt(nxt_shift[12:0]);
          end
        end
        acsp_pkg::ACSP_DATA:
        begin
          if (bitCnt_ff == 4'h7)
          begin
            nxt_bitCnt = 4'h0;
            rxByte     = nxt_shift[7:0];
            wrEn       = !read_ff;
            wrByte     = lsbFirst_ff ? mirror(rxByte) : rxByte; // RULE9
            nxtAddrUse = addr_ff + 13'h1; // RULE16
            nxt_addr   = nxtAddrUse;
            memRead    = readAt(nxtAddrUse);
            nxt_txByte = memRead;
            if (!stream_ff)
            begin
              if (bytesLeft_ff == 2'h0)
              begin
                nxt_state = acsp_pkg::ACSP_IDLE;
              end
              nxt_bytesLeft = bytesLeft_ff - 2'h1; // RULE5
            end
          end
        end
        default:
        begin
          nxt_state = acsp_pkg::ACSP_IDLE;
        end
      endcase
    end
    else if (fall)
    begin
      if (state_ff == acsp_pkg::ACSP_DATA && read_ff)
      begin
        nxt_oe  = 1'b1; // RULE7 RULE8
        nxt_sdo = lsbFirst_ff ? txByte_ff[bitCnt_ff[2:0]]
                              : txByte_ff[3'h7 - bitCnt_ff[2:0]]; // RULE15 RULE9
      end
      else
      begin
        nxt_oe = 1'b0;
      end
    end
  end

  assign xferEn = wrEn && addr_ff == `ACSP_ADDR_TRANSFER && wrByte[`ACSP_TRANSFER_POS];
  assign nxt_lsbFirst = (wrEn && addr_ff == `ACSP_ADDR_CONFIG)
                        ? wrByte[`ACSP_CONFIG_LSB_POS] : lsbFirst_ff; // RULE13

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff     <= acsp_pkg::ACSP_IDLE;
      shift_ff     <= 16'h0000;
      bitCnt_ff    <= 4'h0;
      bytesLeft_ff <= 2'h0;
      stream_ff    <= 1'b0;
      read_ff      <= 1'b0;
      addr_ff      <= 13'h0000;
      txByte_ff    <= 8'h00;
      sdo_ff       <= 1'b0;
      oe_ff        <= 1'b0;
      lsbFirst_ff  <= 1'b0;
    end
    else if (clockEnable)
    begin
      state_ff     <= nxt_state;
      shift_ff     <= nxt_shift;
      bitCnt_ff    <= nxt_bitCnt;
      bytesLeft_ff <= nxt_bytesLeft;
      stream_ff    <= nxt_stream;
      read_ff      <= nxt_read;
      addr_ff      <= nxt_addr;
      txByte_ff    <= nxt_txByte;
      sdo_ff       <= nxt_sdo;
      oe_ff        <= nxt_oe;
      lsbFirst_ff  <= nxt_lsbFirst;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shadow and active byte storage
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : gByte
      localparam logic [7:0] RST = (g == 0) ? `ACSP_CONFIG_RESET : 8'h00;
      logic [7:0] nxt_shadowByte;
      logic [7:0] nxt_activeByte;
      always_comb
      begin
        nxt_shadowByte = shadow_ff[g];
        nxt_activeByte = activeByte_ff[g];
        if (wrEn && addr_ff == 13'(g))
        begin
          nxt_shadowByte = wrByte; // RULE12
          if (g == 0)
          begin
            nxt_shadowByte[`ACSP_CONFIG_SOFT_POS] = 1'b0; // RULE13
          end
        end
        if (xferEn)
        begin
          nxt_activeByte = shadow_ff[g]; // RULE14
        end
        if (g == `ACSP_ADDR_TRANSFER)
        begin
          nxt_shadowByte = 8'h00;
        end
      end
      always_ff @(posedge clock or negedge rstn)
      begin
        if (!rstn)
        begin
          shadow_ff[g]     <= RST;
          activeByte_ff[g] <= RST;
        end
        else if (clockEnable)
        begin
          shadow_ff[g]     <= nxt_shadowByte;
          activeByte_ff[g] <= nxt_activeByte;
        end
      end
    end
  endgenerate

  assign link.dataFromDevice = sdo_ff;
  assign link.dataDeviceOe   = oe_ff; // RULE8
endmodule

// File: rtl/acsp_regs.svh
// Constants of the configuration serial port
`ifndef ACSP_REGS_SVH
`define ACSP_REGS_SVH
`define ACSP_INSTR_BITS      16
`define ACSP_ADDR_BITS       13
`define ACSP_RW_POS          15
`define ACSP_LEN_HI_POS      14
`define ACSP_LEN_LO_POS      13
`define ACSP_LEN_STREAM      2'h3
`define ACSP_ADDR_CONFIG     13'h0000
`define ACSP_ADDR_CHIPID     13'h0001
`define ACSP_ADDR_TRANSFER   13'h00ff
`define ACSP_CONFIG_RESET    8'h18
`define ACSP_CONFIG_LSB_POS  6
`define ACSP_CONFIG_SOFT_POS 5
`define ACSP_TRANSFER_POS    0
`define ACSP_CHIPID_VALUE    8'ha5
`define ACSP_MEM_DEPTH       256
`define ACSP_CLKDIV_HALF     8'h0a
`endif

// File: rtl/acsp_pkg.sv
// Types of the configuration serial port
package acsp_pkg;
  typedef enum logic [1:0]
  {
    ACSP_IDLE  = 2'b00,
    ACSP_INSTR = 2'b01,
    ACSP_DATA  = 2'b11
  } acsp_state_type;
endpackage

// File: rtl/acsp_link_if.sv
// Three-wire link between programming master and device
interface acsp_link_if;
  logic serialClock;
  logic chipSelectN;
  logic dataFromMaster;
  logic dataMasterOe;
  logic dataFromDevice;
  logic dataDeviceOe;
  wire  dataLine = dataDeviceOe ? dataFromDevice : (dataMasterOe ? dataFromMaster : 1'b0);
  modport device
  (
    input  serialClock,
    input  chipSelectN,
    input  dataLine,
    output dataFromDevice,
    output dataDeviceOe
  );
  modport master
  (
    output serialClock,
    output chipSelectN,
    output dataFromMaster,
    output dataMasterOe,
    input  dataLine
  );
endinterface

// File: rtl/acsp_master.sv
// Master end: drives serial clock, select and one whole frame
`include "acsp_regs.svh"
module acsp_master
(
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic         clockEnable,
  acsp_link_if.master       link,
  input  wire logic         start,
  input  wire logic         readCmd,
  input  wire logic [1:0]   lengthCode,
  input  wire logic [12:0]  address,
  input  wire logic [31:0]  writeData,
  input  wire logic         lsbFirst,
  output logic              busy_ff,
  output logic              done_ff,
  output logic [31:0]       readData_ff
);
  //////////////////////////////////////////////////////////////////////////////
  // Frame sequencer
  logic [1:0]  sdiSync_ff;
  logic [7:0]  div_ff, nxt_div;
  logic        sclk_ff, nxt_sclk;
  logic        csn_ff, nxt_csn;
  logic        sdo_ff, nxt_sdo;
  logic        oe_ff, nxt_oe;
  logic [5:0]  bitIdx_ff, nxt_bitIdx;
  logic [5:0]  total_ff, nxt_total;
  logic [47:0] frame_ff, nxt_frame;
  logic        rd_ff, nxt_rd;
  logic        nxt_busy;
  logic        nxt_done;
  logic [31:0] nxt_readData;
  logic [5:0]  dataBits;
  logic [15:0] instr;
  logic        tick;
  logic        lsb_ff, nxt_lsb;
  assign dataBits = {({1'b0, lengthCode} + 3'h1), 3'h0};
  assign instr    = {readCmd, lengthCode, address}; // RULE2
  assign tick     = div_ff == `ACSP_CLKDIV_HALF;

  function automatic logic [31:0] mirrorBytes(input logic [31:0] w);
    for (int i = 0; i < 32; i++)
    begin
      mirrorBytes[i] = w[(i & ~7) + 7 - (i & 7)];
    end
  endfunction

  always_comb
  begin
    nxt_div      = tick ? 8'h00 : div_ff + 8'h01;
    nxt_sclk     = sclk_ff;
    nxt_csn      = csn_ff;
    nxt_sdo      = sdo_ff;
    nxt_oe       = oe_ff;
    nxt_bitIdx   = bitIdx_ff;
    nxt_total    = total_ff;
    nxt_frame    = frame_ff;
    nxt_rd       = rd_ff;
    nxt_busy     = busy_ff;
    nxt_done     = 1'b0;
    nxt_readData = readData_ff;
    nxt_lsb      = lsb_ff;
    if (!busy_ff)
    begin
      nxt_div = 8'h00;
      if (start)
      begin
        nxt_busy   = 1'b1;
        nxt_csn    = 1'b0; // RULE1
        nxt_frame  = {instr, lsbFirst ? mirrorBytes(writeData) : writeData}; // RULE9
        nxt_lsb    = lsbFirst;
        nxt_total  = 6'd16 + dataBits;
        nxt_rd     = readCmd;
        nxt_bitIdx = 6'h0;
        nxt_oe     = 1'b0;
        nxt_sdo    = instr[15];
      end
    end
    else if (tick)
    begin
      if (!sclk_ff)
      begin
        if (bitIdx_ff == total_ff)
        begin
          nxt_csn  = 1'b1;
          nxt_oe   = 1'b0;
          nxt_busy = 1'b0;
          nxt_done = 1'b1;
          nxt_readData = lsb_ff ? mirrorBytes(readData_ff) : readData_ff; // RULE9
        end
        else
        begin
          nxt_sclk = 1'b1; // RULE11
          if (rd_ff && bitIdx_ff >= 6'd16)
          begin
            nxt_readData = {readData_ff[30:0], sdiSync_ff[1]};
          end
        end
      end
      else
      begin
        nxt_sclk   = 1'b0;
        nxt_bitIdx = bitIdx_ff + 6'h1;
        nxt_frame  = {frame_ff[46:0], 1'b0};
        nxt_oe     = !(rd_ff && bitIdx_ff >= 6'd15); // RULE8
        nxt_sdo    = frame_ff[46]; // RULE11
      end
    end
    else if (bitIdx_ff == 6'h0 && !sclk_ff && div_ff == 8'h04)
    begin
      nxt_oe = 1'b1; // RULE8
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sdiSync_ff  <= 2'h0;
      div_ff      <= 8'h00;
      sclk_ff     <= 1'b0;
      csn_ff      <= 1'b1;
      sdo_ff      <= 1'b0;
      oe_ff       <= 1'b0;
      bitIdx_ff   <= 6'h0;
      total_ff    <= 6'h0;
      frame_ff    <= 48'h0;
      rd_ff       <= 1'b0;
      busy_ff     <= 1'b0;
      done_ff     <= 1'b0;
      readData_ff <= 32'h0;
      lsb_ff      <= 1'b0;
    end
    else if (clockEnable)
    begin
      sdiSync_ff  <= {sdiSync_ff[0], link.dataLine};
      div_ff      <= nxt_div;
      sclk_ff     <= nxt_sclk;
      csn_ff      <= nxt_csn;
      sdo_ff      <= nxt_sdo;
      oe_ff       <= nxt_oe;
      bitIdx_ff   <= nxt_bitIdx;
      total_ff    <= nxt_total;
      frame_ff    <= nxt_frame;
      rd_ff       <= nxt_rd;
      busy_ff     <= nxt_busy;
      done_ff     <= nxt_done;
      readData_ff <= nxt_readData;
      lsb_ff      <= nxt_lsb;
    end
  end

  assign link.serialClock    = sclk_ff;
  assign link.chipSelectN    = csn_ff;
  assign link.dataFromMaster = sdo_ff;
  assign link.dataMasterOe   = oe_ff;
endmodule

// File: sim/acsp_link_sva.sv
// Checker for the three-wire link between master and device
module acsp_link_sva
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic serialClock,
  input wire logic chipSelectN,
  input wire logic dataFromMaster,
  input wire logic dataMasterOe,
  input wire logic dataFromDevice,
  input wire logic dataDeviceOe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  // Sequences
  sequence s_high11;
    serialClock[*8] ##1 serialClock[*2] ##1 !serialClock;
  endsequence
  sequence s_first_rise;
    !serialClock ##[9:11] $rose(serialClock);
  endsequence
  sequence s_hold;
    $stable(dataFromMaster)[*8];
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  // Properties
  property p_sclk_half;
    $rose(serialClock) |=> s_high11;
  endproperty
  property p_first_rise;
    $fell(chipSelectN) |-> s_first_rise;
  endproperty
  property p_idle_low;
    $rose(chipSelectN) |-> !serialClock;
  endproperty
  property p_oe_release;
    chipSelectN[*8] |-> !dataDeviceOe;
  endproperty
  property p_no_clash;
    dataDeviceOe |-> !dataMasterOe;
  endproperty
  property p_oe_rise;
    $rose(dataDeviceOe) |-> !serialClock && !chipSelectN;
  endproperty
  property p_dev_change;
    dataDeviceOe && $past(dataDeviceOe) && $changed(dataFromDevice) |-> !serialClock;
  endproperty
  property p_mst_hold;
    $rose(serialClock) && dataMasterOe |-> s_hold;
  endproperty
  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_sclk_half: assert property (p_sclk_half)
    else $error("serial clock high phase not 11 cycles");
  a_first_rise: assert property (p_first_rise)
    else $error("no clock rise after select fell");
  a_idle_low: assert property (p_idle_low)
    else $error("select rose with clock high");
  a_oe_release: assert property (p_oe_release)
    else $error("device drives while deselected");
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive data line");
  a_oe_rise: assert property (p_oe_rise)
    else $error("device enable rose at wrong point");
  a_dev_change: assert property (p_dev_change)
    else $error("readback bit changed with clock high");
  a_mst_hold: assert property (p_mst_hold)
    else $error("master data moved around clock rise");
endmodule

// File: sim/acsp_tb_top.sv
// Testbench: master and device joined, plus a bench-driven device
module acsp_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock;
  logic        rstn;
  logic        start;
  logic        readCmd;
  logic [1:0]  lengthCode;
  logic [12:0] address;
  logic [31:0] writeData;
  logic        lsbFirst;
  logic        busy;
  logic        done;
  logic [31:0] readData;
  logic [7:0]  act1 [256];
  logic [7:0]  act2 [256];
  logic        lsb1;
  logic        lsb2;
  logic [47:0] wireBits;
  int          fails;
  int          samples_checked;
  acsp_link_if link1();
  acsp_link_if link2();
  acsp_master acsp_master_inst
  (
    .clock(clock), .rstn(rstn), .clockEnable(1'b1), .link(link1), .start(start),
    .readCmd(readCmd), .lengthCode(lengthCode), .address(address), .writeData(writeData),
    .lsbFirst(lsbFirst), .busy_ff(busy), .done_ff(done), .readData_ff(readData)
  );
  acsp_device acsp_device_inst
  (
    .clock(clock), .rstn(rstn), .clockEnable(1'b1), .link(link1), .activeByte_ff(act1),
    .lsbFirst_ff(lsb1)
  );
  acsp_device acsp_device_inst2
  (
    .clock(clock), .rstn(rstn), .clockEnable(1'b1), .link(link2), .activeByte_ff(act2),
    .lsbFirst_ff(lsb2)
  );
  acsp_link_sva acsp_link_sva_inst
  (
    .clock(clock), .rstn(rstn), .serialClock(link1.serialClock),
    .chipSelectN(link1.chipSelectN), .dataFromMaster(link1.dataFromMaster),
    .dataMasterOe(link1.dataMasterOe), .dataFromDevice(link1.dataFromDevice),
    .dataDeviceOe(link1.dataDeviceOe)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, wire monitor, watchdog
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge link1.serialClock)
    wireBits <= {wireBits[46:0], link1.dataLine};
  initial
  begin
    repeat (80000) @(posedge clock);
    fails++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string what, input logic [47:0] expv, input logic [47:0] seen);
    samples_checked++;
    if (seen !== expv)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task automatic frame(input logic rd, input logic [1:0] len, input logic [12:0] adr,
                       input logic [31:0] wd, input logic lsb);
    int k;
    @(posedge clock);
    readCmd <= rd;
    lengthCode <= len;
    address <= adr;
    writeData <= wd;
    lsbFirst <= lsb;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    #1;
    chk("busy", 48'h1, {47'h0, busy});
    for (k = 0; k < 3000 && done !== 1'b1; k++)
    begin
      @(posedge clock);
      #1;
    end
    chk("done", 48'h1, {47'h0, done});
  endtask
  task automatic bang(input logic [31:0] v, input int n);
    int b;
    for (b = n - 1; b >= 0; b--)
    begin
      link2.dataFromMaster <= v[b];
      repeat (10) @(posedge clock);
      link2.serialClock <= 1'b1;
      repeat (10) @(posedge clock);
      link2.serialClock <= 1'b0;
    end
  endtask
  task automatic sel(input logic v);
    link2.chipSelectN <= v;
    repeat (10) @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_reset();
    @(posedge clock);
    #1;
    chk("config reset", 48'h18, {40'h0, act1[0]});
    chk("order reset", 48'h0, {47'h0, lsb1});
    $display("test reset done");
  endtask
  task automatic test_lengths(input logic lsb, input logic [12:0] base);
    int i;
    logic [31:0] wd;
    logic [12:0] adr;
    logic [47:0] expW;
    logic [47:0] mask;
    for (i = 0; i < 4; i++)
    begin
      adr = base + 13'(4 * i);
      wd = 32'hc3a55a3c + 32'(i) * 32'h01010101;
      frame(1'b0, 2'(i), adr, wd, lsb);
      expW = {1'b0, 2'(i), adr, wd} >> (24 - 8 * i);
      mask = (48'h1 << (24 + 8 * i)) - 48'h1;
      if (!lsb)
        chk("wire frame", expW, wireBits & mask);
      chk("active early", 48'h0, {40'h0, act1[adr]});
      frame(1'b0, 2'h0, 13'h00ff, 32'h01000000, lsb);
      chk("active first", {40'h0, wd[31:24]}, {40'h0, act1[adr]});
      chk("active last", {40'h0, wd[31 - 8 * i -: 8]}, {40'h0, act1[adr + 13'(i)]});
      frame(1'b1, 2'(i), adr, 32'h0, lsb);
      mask = (48'h1 << (8 * i + 8)) - 48'h1;
      chk("readback", {16'h0, wd >> (24 - 8 * i)}, {16'h0, readData} & mask);
    end
    $display("test lengths done");
  endtask
  task automatic test_link2();
    int j;
    @(posedge clock);
    sel(1'b0);
    bang(32'h2030, 16);
    bang(32'h5a, 8);
    sel(1'b1);
    bang(32'hff, 8);
    sel(1'b0);
    bang(32'h3c, 8);
    sel(1'b1);
    sel(1'b0);
    bang(32'h0040, 16);
    bang(32'hf, 4);
    sel(1'b1);
    sel(1'b0);
    bang(32'h0041, 16);
    bang(32'h77, 8);
    sel(1'b1);
    sel(1'b0);
    bang(32'h6050, 16);
    bang(32'h01020304, 32);
    sel(1'b1);
    sel(1'b0);
    bang(32'h00ff, 16);
    bang(32'h01, 8);
    sel(1'b1);
    chk("stalled first", 48'h5a, {40'h0, act2[8'h30]});
    chk("stalled second", 48'h3c, {40'h0, act2[8'h31]});
    chk("aborted", 48'h0, {40'h0, act2[8'h40]});
    chk("after abort", 48'h77, {40'h0, act2[8'h41]});
    for (j = 0; j < 4; j++)
      chk("stream", 48'(j + 1), {40'h0, act2[8'h50 + j]});
    $display("test bench link done");
  endtask
  task automatic test_bit_order();
    frame(1'b0, 2'h0, 13'h0000, 32'h5a000000, 1'b0);
    chk("order set", 48'h1, {47'h0, lsb1});
    test_lengths(1'b1, 13'h0080);
    $display("test bit order done");
  endtask
  task automatic final_report();
    $display("Counts: %0d checked, %0d mismatched", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rstn = 1'b0;
    start = 1'b0;
    readCmd = 1'b0;
    lengthCode = 2'h0;
    address = 13'h0;
    writeData = 32'h0;
    lsbFirst = 1'b0;
    link2.serialClock = 1'b0;
    link2.chipSelectN = 1'b1;
    link2.dataFromMaster = 1'b0;
    link2.dataMasterOe = 1'b1;
    wireBits = 48'h0;
    fails = 0;
    samples_checked = 0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    test_reset();
    test_lengths(1'b0, 13'h0010);
    test_link2();
    test_bit_order();
    final_report();
  end
endmodule
